// ==== verilog/tape_ctrl_regs.vh ====
// constants for the tape controller status and spacing block
// included by the controller design file; no definitions of logic here
`ifndef TAPE_CTRL_REGS_VH
`define TAPE_CTRL_REGS_VH
// extended status bit positions (bit 0 is the lsb of the word)
`define XS_ERR        15
`define XS_RUNAWAY    14
`define XS_FALSE_GAP  13
`define XS_CORR_LATE  11
`define XS_FIELD_HI   10
`define XS_FIELD_LO   8
`define XS_OVERFLOW   7
`define XS_WEAK       6
`define XS_SKEW       5
`define XS_CHECK      4
`define XS_ONE_TRACK  3
`define XS_POSTAMBLE  2
`define XS_FORMAT     1
`define XS_PE_MODE    0
// mask of bits that feed the summary error bit: host bits 2..6, 11, 13
`define XS_ERR_MASK   16'h287c
// primary status bit positions used here
`define PS_EOT        9
`define PS_EOF        8
`define PS_BOT        7
`define PS_ERR        15
// reset values
`define RST_WORD      16'h0000
// runaway time in milliseconds and clock period in ns
`define RUNAWAY_MS    3000
`define CLK_NS        25
`endif

// ==== verilog/drive_scan.v ====
// status check scanner: watches six flags of each of eight drives
// assumes drive flags are already synchronised to mclk
`timescale 1ns/1ps
module drive_scan
#(
    parameter UNITS = 8
)
(
    input  wire                mclk,
    input  wire                nrst,
    input  wire                scan_on,
    input  wire [6*UNITS-1:0]  unit_flags,
    input  wire                ack,
    output wire                change,
    output reg  [2:0]          change_unit
);
    reg  [6*UNITS-1:0] seen_r;
    reg                pend_r;
    reg  [2:0]         idx_r;
    wire [5:0]         cur;
    wire [5:0]         old;
    assign cur    = unit_flags[idx_r*6 +: 6];
    assign old    = seen_r[idx_r*6 +: 6];
    assign change = scan_on & ~pend_r & (cur != old);
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            seen_r      <= {6*UNITS{1'b0}};
            pend_r      <= 1'b0;
            idx_r       <= 3'h0;
            change_unit <= 3'h0;
        end
        else if (!scan_on)
        begin
            seen_r <= {6*UNITS{1'b0}};
            pend_r <= 1'b0;
            idx_r  <= 3'h0;
        end
        else if (pend_r)
        begin
            if (ack)
                pend_r <= 1'b0;
        end
        else
        begin
            if (cur != old)
            begin
                pend_r      <= 1'b1;
                change_unit <= idx_r;
                seen_r[idx_r*6 +: 6] <= cur;
            end
            idx_r <= (idx_r == UNITS-1) ? 3'h0 : idx_r + 3'h1;
        end
    end
endmodule // drive_scan

// ==== verilog/tape_ctrl.v ====
// tape controller: extended status, address and count, spacing, status check
// assumes io bus strobes are mclk-synchronous; tape events come from pins
`timescale 1ns/1ps
`include "tape_ctrl_regs.vh"
module tape_ctrl
#(
    parameter UNITS          = 8,
    parameter RUNAWAY_CYCLES = `RUNAWAY_MS * (1000000 / `CLK_NS)
)
(
    input  wire                mclk,
    input  wire                nrst,
    input  wire                io_clear,
    input  wire                io_start,
    input  wire [15:0]         io_data,
    input  wire                write_output_a,
    input  wire                write_output_b,
    input  wire                write_output_c,
    input  wire                read_input_b,
    input  wire                read_input_c,
    output reg  [15:0]         rd_data,
    input  wire                chan_word,
    input  wire                rec_end,
    input  wire                tape_moving,
    input  wire                ev_false_gap,
    input  wire                ev_corr_late,
    input  wire                ev_retry,
    input  wire                ev_long_rec,
    input  wire                ev_weak,
    input  wire                ev_skew,
    input  wire                ev_check,
    input  wire                ev_one_track,
    input  wire                ev_postamble,
    input  wire                ev_format,
    input  wire                pe_mode,
    input  wire                ev_file_mark,
    input  wire                ev_eot,
    input  wire                ev_bot,
    input  wire                op_finish,
    input  wire [6*UNITS-1:0]  unit_flags,
    output wire [15:0]         transfer_memory_address,
    output reg                 busy,
    output reg                 done,
    output reg                 scan_irq,
    output reg  [15:0]         primary_flags
);
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_XFER  = 4'b0010;
    localparam [3:0] ST_SPACE = 4'b0100;
    localparam [3:0] ST_OTHER = 4'b1000;
    localparam [4:0] CMD_REWIND = 5'b00001;
    localparam [4:0] CMD_CTRL   = 5'b00010;
    localparam [4:0] CMD_SPF    = 5'b00011;
    localparam [4:0] CMD_SPR    = 5'b00100;
    localparam [4:0] CMD_UNLOAD = 5'b10001;
    localparam [31:0] RUN_LIM = RUNAWAY_CYCLES;

    reg  [3:0]  state_r;
    reg  [15:0] cmd_r;
    reg  [15:0] addr_r;
    reg  [15:0] count_r;
    reg  [15:0] xs_r;
    reg         space_wrap_r;
    reg  [31:0] run_cnt_r;
    reg  [2:0]  retry_r;
    reg         scan_on_r;
    reg         scan_seen_r;
    reg  [2:0]  file_sync_r;
    reg  [2:0]  file_sync2_r;
    wire        scan_change;
    wire [2:0]  scan_unit;
    wire        clr_int;
    wire [15:0] xs_view;
    wire [4:0]  cmd_field;
    wire        stop_mark;

    // command field with the ignored bit masked out
    function [4:0] cmd_of;
        input [15:0] w;
        begin
            cmd_of = {w[7], 1'b0, w[5:3]};
        end
    endfunction

    // space-terminating pins pass two flip-flops
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            file_sync_r  <= 3'h0;
            file_sync2_r <= 3'h0;
        end
        else
        begin
            file_sync_r  <= {ev_file_mark, ev_eot, ev_bot};
            file_sync2_r <= file_sync_r;
        end
    end

    assign cmd_field = cmd_of(cmd_r);
    assign stop_mark = |file_sync2_r;
    assign clr_int   = write_output_a & io_data[15];
    assign transfer_memory_address = addr_r;

    // unit/retry field; the summary bit is formed at read time
    assign xs_view = {xs_r[15], xs_r[14:12], xs_r[11],
                      scan_seen_r ? scan_unit : retry_r,
                      xs_r[7:0]};

    drive_scan #(
        .UNITS       (UNITS)
    ) u_scan (
        .mclk        (mclk),
        .nrst        (nrst),
        .scan_on     (scan_on_r),
        .unit_flags  (unit_flags),
        .ack         (clr_int),
        .change      (scan_change),
        .change_unit (scan_unit)
    );

    // register reads
    always @*
    begin
        rd_data = `RST_WORD;
        if (read_input_c)
            rd_data = {|(xs_view & `XS_ERR_MASK), xs_view[14:0]};
        else if (read_input_b)
            rd_data = addr_r;
    end

    // operation sequencing
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r       <= ST_IDLE;
            cmd_r         <= `RST_WORD;
            addr_r        <= `RST_WORD;
            count_r       <= `RST_WORD;
            xs_r          <= `RST_WORD;
            space_wrap_r  <= 1'b0;
            run_cnt_r     <= 32'h0;
            retry_r       <= 3'h0;
            scan_on_r     <= 1'b0;
            scan_seen_r   <= 1'b0;
            scan_irq      <= 1'b0;
            busy          <= 1'b0;
            done          <= 1'b0;
            primary_flags <= `RST_WORD;
        end
        else if (io_clear)
        begin
            state_r       <= ST_IDLE;
            cmd_r         <= `RST_WORD;
            addr_r        <= `RST_WORD;
            xs_r          <= `RST_WORD;
            retry_r       <= 3'h0;
            run_cnt_r     <= 32'h0;
            scan_on_r     <= 1'b0;
            scan_seen_r   <= 1'b0;
            scan_irq      <= 1'b0;
            busy          <= 1'b0;
            done          <= 1'b0;
            primary_flags <= `RST_WORD;
        end
        else
        begin
            // command load; clear-only form keeps the command
            if (write_output_a && !io_data[15])
                cmd_r <= io_data;
            if (write_output_a && cmd_of(io_data) == CMD_CTRL)
            begin
                scan_on_r <= io_data[10];
                if (io_data[10] && !scan_on_r)
                    scan_irq <= 1'b1;
            end
            if (write_output_b)
                addr_r <= io_data;
            if (write_output_c)
                count_r <= {io_data[14], io_data[14:0]};

            // status change interrupt, set wins over clear
            if (scan_change && scan_on_r)
            begin
                scan_irq    <= 1'b1;
                scan_seen_r <= 1'b1;
            end
            else if (clr_int)
                scan_irq <= 1'b0;

            // error capture
            xs_r[`XS_PE_MODE] <= pe_mode;
            if (state_r != ST_IDLE)
            begin
                if (ev_false_gap) xs_r[`XS_FALSE_GAP] <= 1'b1;
                if (ev_corr_late) xs_r[`XS_CORR_LATE] <= 1'b1;
                if (ev_long_rec)  xs_r[`XS_OVERFLOW]  <= 1'b1;
                if (ev_weak)      xs_r[`XS_WEAK]      <= 1'b1;
                if (ev_skew)      xs_r[`XS_SKEW]      <= 1'b1;
                if (ev_check)     xs_r[`XS_CHECK]     <= 1'b1;
                if (ev_one_track && pe_mode)
                    xs_r[`XS_ONE_TRACK] <= 1'b1;
                if (ev_postamble) xs_r[`XS_POSTAMBLE] <= 1'b1;
                if (ev_format)    xs_r[`XS_FORMAT]    <= 1'b1;
                if (ev_retry && retry_r != 3'h7)
                    retry_r <= retry_r + 3'h1;
            end

            // runaway timer during motion
            if ((state_r == ST_XFER || state_r == ST_SPACE) && tape_moving)
            begin
                if (rec_end)
                    run_cnt_r <= 32'h0;
                else if (run_cnt_r >= RUN_LIM - 32'h1)
                    xs_r[`XS_RUNAWAY] <= 1'b1;
                else
                    run_cnt_r <= run_cnt_r + 32'h1;
            end

            case (state_r)
                ST_IDLE:
                begin
                    if (io_start)
                    begin
                        done        <= 1'b0;
                        busy        <= cmd_field != CMD_REWIND &&
                                       cmd_field != CMD_UNLOAD;
                        run_cnt_r   <= 32'h0;
                        retry_r     <= 3'h0;
                        scan_seen_r <= 1'b0;
                        primary_flags <= `RST_WORD;
                        if (cmd_field == CMD_SPF || cmd_field == CMD_SPR)
                        begin
                            state_r      <= ST_SPACE;
                            space_wrap_r <= count_r == 16'h0000;
                        end
                        else if (cmd_field[3:0] == 4'b0000 || cmd_field == 5'b00101)
                            state_r <= ST_XFER;
                        else if (cmd_field == CMD_REWIND || cmd_field == CMD_UNLOAD)
                            state_r <= ST_IDLE;
                        else
                            state_r <= ST_OTHER;
                    end
                end
                ST_XFER:
                begin
                    if (chan_word)
                    begin
                        addr_r  <= addr_r + 16'h0001;
                        count_r <= count_r + 16'h0001;
                    end
                    if (op_finish)
                    begin
                        state_r <= ST_IDLE;
                        busy    <= 1'b0;
                        done    <= 1'b1;
                    end
                end
                ST_SPACE:
                begin
                    if (stop_mark)
                    begin
                        primary_flags[`PS_EOF] <= file_sync2_r[2];
                        primary_flags[`PS_EOT] <= file_sync2_r[1];
                        primary_flags[`PS_BOT] <= file_sync2_r[0];
                        primary_flags[`PS_ERR] <= |file_sync2_r;
                        state_r <= ST_IDLE;
                        busy    <= 1'b0;
                        done    <= 1'b1;
                    end
                    else if (rec_end)
                    begin
                        count_r      <= count_r + 16'h0001;
                        space_wrap_r <= 1'b0;
                        if (count_r == 16'hffff && !space_wrap_r)
                        begin
                            state_r <= ST_IDLE;
                            busy    <= 1'b0;
                            done    <= 1'b1;
                        end
                    end
                end
                ST_OTHER:
                begin
                    if (op_finish)
                    begin
                        state_r <= ST_IDLE;
                        busy    <= 1'b0;
                        done    <= 1'b1;
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // tape_ctrl

// ==== testbench/tape_ctrl_props.sv ====
// assertions on the tape controller ports
// assumes a single mclk domain and active-low async nrst
`timescale 1ns/1ps
module tape_ctrl_props
(
    input wire        mclk,
    input wire        nrst,
    input wire        io_clear,
    input wire        io_start,
    input wire [15:0] io_data,
    input wire        write_output_a,
    input wire        write_output_b,
    input wire        read_input_b,
    input wire        read_input_c,
    input wire [15:0] rd_data,
    input wire        chan_word,
    input wire [15:0] transfer_memory_address,
    input wire        busy,
    input wire        done,
    input wire        scan_irq,
    input wire [15:0] primary_flags
);
    reg mode_on_r;
    // status check mode as last commanded by the host
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            mode_on_r <= 1'b0;
        else if (io_clear)
            mode_on_r <= 1'b0;
        else if (write_output_a && !io_data[7] && io_data[5:3] == 3'b010)
            mode_on_r <= io_data[10];
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    err_summary_a: assert property (read_input_c |-> rd_data[15] == |(rd_data & 16'h287c))
        else $error("summary error bit wrong");
    start_busy_a: assert property ($rose(busy) |-> $past(io_start))
        else $error("busy rose without start");
    start_done_a: assert property (io_start && !busy |=> !done)
        else $error("done not cleared by start");
    clear_abort_a: assert property (io_clear |=> !busy)
        else $error("clear did not abort");
    addr_load_a: assert property (write_output_b |=> transfer_memory_address == $past(io_data))
        else $error("address load wrong");
    addr_step_a: assert property (busy && chan_word && !write_output_b && !io_clear
        |=> transfer_memory_address == $past(transfer_memory_address) + 16'h0001)
        else $error("address did not step");
    addr_read_a: assert property (read_input_b && !read_input_c
        |-> rd_data == transfer_memory_address)
        else $error("address read wrong");
    done_idle_a: assert property ($rose(done) |-> !busy)
        else $error("done with busy set");
    eof_err_a: assert property ($rose(primary_flags[8]) |-> primary_flags[15])
        else $error("file mark without error");
    scan_entry_a: assert property (write_output_a && !io_data[15] && io_data[10] && !io_data[7]
        && io_data[5:3] == 3'b010 && !mode_on_r && !io_clear |-> ##[1:4] scan_irq)
        else $error("no interrupt on scan entry");
    cover property ($rose(scan_irq));
    cover property ($rose(done) && primary_flags[8]);
    cover property (busy && chan_word);
endmodule // tape_ctrl_props
bind tape_ctrl tape_ctrl_props tape_ctrl_props_i (.mclk(mclk), .nrst(nrst), .io_clear(io_clear),
    .io_start(io_start), .io_data(io_data), .write_output_a(write_output_a),
    .write_output_b(write_output_b), .read_input_b(read_input_b), .read_input_c(read_input_c),
    .rd_data(rd_data), .chan_word(chan_word), .transfer_memory_address(transfer_memory_address),
    .busy(busy), .done(done), .scan_irq(scan_irq), .primary_flags(primary_flags));

// ==== testbench/tape_drive_model.sv ====
// tape transport model: record ends at a fixed gap, optional file mark
// assumes run is held by the bench for the whole spacing operation
`timescale 1ns/1ps
module tape_drive_model
#(
    parameter GAP = 8
)
(
    input  wire       mclk,
    input  wire       nrst,
    input  wire       run,
    input  wire [7:0] mark_at,
    output reg        rec_end,
    output reg        file_mark
);
    reg [3:0] gap_r;
    reg [7:0] recs_r;
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst || !run)
        begin
            gap_r     <= 4'h0;
            recs_r    <= 8'h00;
            rec_end   <= 1'b0;
            file_mark <= 1'b0;
        end
        else
        begin
            // record end well inside the runaway time
            rec_end <= (gap_r == GAP - 1);
            gap_r   <= (gap_r == GAP - 1) ? 4'h0 : gap_r + 4'h1;
            if (gap_r == GAP - 1)
                recs_r <= recs_r + 8'h01;
            file_mark <= (mark_at != 8'h00) && (recs_r >= mark_at);
        end
    end
endmodule // tape_drive_model

// ==== testbench/test_tape_ctrl.sv ====
// self-checking bench for the tape controller
// assumes tape_ctrl, its header and the transport model are compiled first
`timescale 1ns/1ps
module test_tape_ctrl;
    reg mclk, nrst, io_clear, io_start, wa, wb, wc, rb, rc, chan_word, mov, pe, eot, bot, fin, run;
    reg  [15:0] io_data, v, e;
    reg  [9:0]  ev;
    reg  [47:0] uf;
    reg  [7:0]  mark_at;
    wire [15:0] rd_data, addr, pf;
    wire        busy, done, scan_irq, rec_end, fm;
    integer     bad_count, compares, recs, i, n;
    localparam [35:0] pos = {4'd1, 4'd2, 4'd3, 4'd4, 4'd5, 4'd6, 4'd7, 4'd11, 4'd13};
    tape_ctrl #(.RUNAWAY_CYCLES(50)) tape_ctrl_i (.mclk(mclk), .nrst(nrst), .io_clear(io_clear),
        .io_start(io_start), .io_data(io_data), .write_output_a(wa), .write_output_b(wb),
        .write_output_c(wc), .read_input_b(rb), .read_input_c(rc), .rd_data(rd_data),
        .chan_word(chan_word), .rec_end(rec_end), .tape_moving(mov), .ev_false_gap(ev[0]),
        .ev_corr_late(ev[1]), .ev_retry(ev[9]), .ev_long_rec(ev[2]), .ev_weak(ev[3]),
        .ev_skew(ev[4]), .ev_check(ev[5]), .ev_one_track(ev[6]), .ev_postamble(ev[7]),
        .ev_format(ev[8]), .pe_mode(pe), .ev_file_mark(fm), .ev_eot(eot), .ev_bot(bot),
        .op_finish(fin), .unit_flags(uf), .transfer_memory_address(addr), .busy(busy),
        .done(done), .scan_irq(scan_irq), .primary_flags(pf));
    tape_drive_model tape_drive_model_i (.mclk(mclk), .nrst(nrst), .run(run),
        .mark_at(mark_at), .rec_end(rec_end), .file_mark(fm));
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk)
        if (rec_end === 1'b1)
            recs = recs + 1;
    task cyc(input integer k);
        begin
            repeat (k) @(posedge mclk);
            #2;
        end
    endtask
    task chk(input [8*8-1:0] what, input [15:0] seen, input [15:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp)
            begin
                bad_count = bad_count + 1;
                $display("unexpected %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wr(input [1:0] k, input [15:0] d);
        begin
            io_data = d;
            case (k)
                2'd0: wa = 1'b1;
                2'd1: wb = 1'b1;
                default: wc = 1'b1;
            endcase
            cyc(1);
            case (k)
                2'd0: wa = 1'b0;
                2'd1: wb = 1'b0;
                default: wc = 1'b0;
            endcase
        end
    endtask
    task rd(input c);
        begin
            if (c)
                rc = 1'b1;
            else
                rb = 1'b1;
            @(negedge mclk) v = rd_data;
            cyc(1);
            if (c)
                rc = 1'b0;
            else
                rb = 1'b0;
        end
    endtask
    task pls(input [1:0] k);
        begin
            case (k)
                2'd0: io_start = 1'b1;
                2'd1: io_clear = 1'b1;
                2'd2: chan_word = 1'b1;
                default: fin = 1'b1;
            endcase
            cyc(1);
            case (k)
                2'd0: io_start = 1'b0;
                2'd1: io_clear = 1'b0;
                2'd2: chan_word = 1'b0;
                default: fin = 1'b0;
            endcase
        end
    endtask
    task go;
        begin
            recs = 0;
            pls(0);
            chk("busy", {14'h0, busy, done}, 16'h0002);
        end
    endtask
    task wait_for(input s);
        begin
            n = 0;
            while (((s ? scan_irq : done) !== 1'b1) && n < 400)
            begin
                cyc(1);
                n = n + 1;
            end
            chk("wait", n < 400, 16'h0001);
        end
    endtask
    task space(input [15:0] cmd, input [15:0] cnt, input [7:0] m, input r);
        begin
            wr(0, cmd);
            wr(2, cnt);
            mark_at = m;
            mov = 1'b1;
            go;
            run = r;
        end
    endtask
    task complete_run;
        begin
            if (bad_count == 0 && compares > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk);
        bad_count = bad_count + 1;
        complete_run;
    end
    initial
    begin
        {nrst, io_clear, io_start, wa, wb, wc, rb, rc, chan_word, mov, eot, bot, fin, run} = 0;
        {io_data, ev, uf, mark_at, bad_count, compares, recs} = 0;
        pe = 1'b1;
        cyc(12);
        nrst = 1'b1;
        for (i = 0; i < 10; i = i + 1)
        begin
            wr(0, 16'h0000);
            go;
            ev[i] = 1'b1;
            if (i == 9)
                cyc(1);
            cyc(1);
            ev = 10'h0;
            cyc(1);
            rd(1);
            e = (i == 9) ? 16'h0200 : 16'h0001 << pos[i*4+:4];
            e = e | 16'h0001 | ((e & 16'h287c) ? 16'h8000 : 16'h0000);
            chk("xstat", v, e);
            pls(1);
            rd(1);
            chk("cleared", {v[15:1], busy}, 16'h0000);
        end
        pe = 1'b0;
        wr(0, 16'h0028);
        wr(1, 16'h1234);
        wr(2, 16'h7ffd);
        go;
        repeat (3)
        begin
            pls(2);
            cyc(1);
        end
        pls(3);
        wait_for(0);
        rd(0);
        chk("address", v, 16'h1237);
        chk("addr pin", addr, 16'h1237);
        space(16'h0018, 16'h7ffe, 8'h00, 1'b1);
        wait_for(0);
        chk("records", recs, 16'h0002);
        run = 1'b0;
        space(16'h0018, 16'h0000, 8'h05, 1'b1);
        wait_for(0);
        run = 1'b0;
        chk("eof", pf & 16'h8380, 16'h8100);
        for (i = 0; i < 2; i = i + 1)
        begin
            space(i ? 16'h0020 : 16'h0018, 16'h0000, 8'h00, 1'b1);
            cyc(20);
            {eot, bot} = i ? 2'b01 : 2'b10;
            wait_for(0);
            {eot, bot, run} = 3'b000;
            chk("tape end", pf & 16'h8380, i ? 16'h8080 : 16'h8200);
        end
        space(16'h0018, 16'h7ffe, 8'h00, 1'b0);
        cyc(60);
        rd(1);
        chk("runaway", v, 16'h4000);
        pls(1);
        mov = 1'b0;
        for (i = 0; i < 2; i = i + 1)
        begin
            wr(0, i ? 16'h0088 : 16'h0008);
            pls(0);
            chk("rewind", {14'h0, busy, done}, 16'h0000);
        end
        wr(0, 16'h0410);
        cyc(3);
        chk("entry", scan_irq, 16'h0001);
        wr(0, 16'h8410);
        cyc(1);
        chk("ack", scan_irq, 16'h0000);
        uf[32] = 1'b1;
        wait_for(1);
        rd(1);
        chk("unit", v[10:8], 16'h0005);
        complete_run;
    end
endmodule // test_tape_ctrl
